// ===== rtl/tsb_regs.svh
// register offsets, field positions, reset values of the timer status block
// assumes an 8-bit byte-addressed bus, 4-bit channel-local address
`ifndef TSB_REGS_SVH
`define TSB_REGS_SVH

// ----------------------------------------------------------------
// channel-local byte offsets
// ----------------------------------------------------------------
`define TSB_ADDR_CTRL_STATUS 4'h1
`define TSB_ADDR_COUNT_HI 4'h2
`define TSB_ADDR_COUNT_LO 4'h3
`define TSB_ADDR_CMP_A_HI 4'h4
`define TSB_ADDR_CMP_A_LO 4'h5
`define TSB_ADDR_CMP_B_HI 4'h6
`define TSB_ADDR_CMP_B_LO 4'h7
`define TSB_ADDR_CAPT_HI 4'h8
`define TSB_ADDR_CAPT_LO 4'h9

// ----------------------------------------------------------------
// status/control field positions
// ----------------------------------------------------------------
`define TSB_BIT_CAPTURE_FLAG 7
`define TSB_BIT_MATCH_B_FLAG 6
`define TSB_BIT_MATCH_A_FLAG 5
`define TSB_BIT_WRAP_FLAG 4
`define TSB_BIT_MATCH_B_LEVEL 3
`define TSB_BIT_MATCH_A_LEVEL 2
`define TSB_BIT_CAPTURE_EDGE_SEL 1
`define TSB_BIT_CLEAR_ON_MATCH_A 0
`define TSB_FLAG_LSB 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TSB_RST_CTRL_STATUS 8'h00
`define TSB_RST_COUNT 16'h0000
`define TSB_RST_COMPARE 16'hFFFF
`define TSB_RST_CAPTURE 16'h0000
`define TSB_COUNT_MAX 16'hFFFF

`endif

// ===== rtl/tsb_pkg.sv
// types shared by the timer status block
// assumes tsb_regs.svh is on the include path
`default_nettype none

package tsb_pkg;
    // one-hot register select
    typedef enum logic [9:0] {
        TSB_SEL_NONE = 10'h001,
        TSB_SEL_CTRL = 10'h002,
        TSB_SEL_CNT_HI = 10'h004,
        TSB_SEL_CNT_LO = 10'h008,
        TSB_SEL_CMPA_HI = 10'h010,
        TSB_SEL_CMPA_LO = 10'h020,
        TSB_SEL_CMPB_HI = 10'h040,
        TSB_SEL_CMPB_LO = 10'h080,
        TSB_SEL_CAP_HI = 10'h100,
        TSB_SEL_CAP_LO = 10'h200
    } tsb_sel_e;
    typedef logic [7:0] tsb_byte_t;
    typedef logic [15:0] tsb_word_t;
endpackage

`default_nettype wire

// ===== rtl/tsb_capture_sync.sv
// capture pin synchroniser with edge detection
// assumes an asynchronous pin and an active-low asynchronous reset
`default_nettype none

module tsb_capture_sync
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pin and edges
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic meta;
    logic sync;
    logic prev;

    // ------------------------------------------------------------
    // two-stage synchroniser, then edge history
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    assign rise = sync & ~prev;
    assign fall = ~sync & prev;
endmodule

`default_nettype wire

// ===== rtl/tsb_timer_status.sv
// timer channel: status/control register, counter, compares, capture
// assumes an 8-bit cpu bus on SYS_CLK with one-cycle read/write strobes
`include "tsb_regs.svh"
`default_nettype none

// How it works
// - capture event copies counter to capture register and sets capture flag
// - writing 1 to flag bits 7..4 never changes them; 0 may clear
// - software clears a flag only after reading it as 1 first
// - transfer controller service of capture or compare clears that flag
// - compare B flag sets when counter equals compare B value
// - compare A flag sets when counter equals compare A value
// - wrap flag sets when counter goes from all ones to zero
// - wrap flag cleared only by read-then-write-0, never by transfer controller
// - bit 3 picks level driven on compare B pin at match
// - bit 2 picks level driven on compare A pin at match
// - bit 1 picks capture edge: 0 falling, 1 rising
// - bit 0 set clears the counter on compare A match
// - status/control register is zero after reset and in standby
// - counter, compares and capture share one 8-bit holding latch
// - upper write goes to latch; lower write loads all 16 bits
// - upper read latches lower byte; lower read returns latch
// - compare register reads bypass the holding latch
// - four interrupt lines, each flag and its enable
// - match signal fires on the last equal state, before advance
// - capture still copies the counter when its flag is already set
// - capture during an upper capture read is delayed one cycle
module tsb_timer_status
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic STANDBY,
    // cpu byte bus
    input wire logic [3:0] CPU_ADDR,
    input wire logic CPU_RD,
    input wire logic CPU_WR,
    input wire tsb_pkg::tsb_byte_t CPU_WDATA,
    output tsb_pkg::tsb_byte_t CPU_RDATA,
    // counter tick and capture pin
    input wire logic COUNT_TICK,
    input wire logic CAPTURE_PIN,
    // enables from the control register
    input wire logic [3:0] IRQ_ENABLE,
    input wire logic OUT_ENABLE_A,
    input wire logic OUT_ENABLE_B,
    // transfer controller service strobes
    input wire logic XFER_SERVE_CAPTURE,
    input wire logic XFER_SERVE_MATCH_A,
    input wire logic XFER_SERVE_MATCH_B,
    // compare pins
    output logic COMPARE_A_OUT_PIN,
    output logic COMPARE_B_OUT_PIN,
    // interrupt requests
    output logic CAPTURE_IRQ,
    output logic MATCH_A_IRQ,
    output logic MATCH_B_IRQ,
    output logic WRAP_IRQ
);
    import tsb_pkg::*;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic tsb_sel_e tsb_decode(input logic [3:0] addr);
        case (addr)
            `TSB_ADDR_CTRL_STATUS: tsb_decode = TSB_SEL_CTRL;
            `TSB_ADDR_COUNT_HI: tsb_decode = TSB_SEL_CNT_HI;
            `TSB_ADDR_COUNT_LO: tsb_decode = TSB_SEL_CNT_LO;
            `TSB_ADDR_CMP_A_HI: tsb_decode = TSB_SEL_CMPA_HI;
            `TSB_ADDR_CMP_A_LO: tsb_decode = TSB_SEL_CMPA_LO;
            `TSB_ADDR_CMP_B_HI: tsb_decode = TSB_SEL_CMPB_HI;
            `TSB_ADDR_CMP_B_LO: tsb_decode = TSB_SEL_CMPB_LO;
            `TSB_ADDR_CAPT_HI: tsb_decode = TSB_SEL_CAP_HI;
            `TSB_ADDR_CAPT_LO: tsb_decode = TSB_SEL_CAP_LO;
            default: tsb_decode = TSB_SEL_NONE;
        endcase
    endfunction

    tsb_sel_e sel;
    logic wr_ctrl;
    logic rd_ctrl;
    logic [7:0] ctrl;
    logic [3:0] flags;
    logic [3:0] armed;
    logic [3:0] flag_set;
    logic [3:0] sw_clr;
    logic [3:0] xfer_clr;
    tsb_word_t free_counter;
    tsb_word_t compare_a_value;
    tsb_word_t compare_b_value;
    tsb_word_t capture_value;
    tsb_byte_t hold;
    logic match_a;
    logic match_b;
    logic wrap;
    logic cap_rise;
    logic cap_fall;
    logic cap_edge;
    logic cap_hi_read;
    logic cap_pending;
    logic cap_fire;
    localparam tsb_byte_t rst_ctrl = `TSB_RST_CTRL_STATUS;

    assign sel = tsb_decode(CPU_ADDR);
    assign wr_ctrl = CPU_WR && (sel == TSB_SEL_CTRL);
    assign rd_ctrl = CPU_RD && (sel == TSB_SEL_CTRL);
    assign flags = ctrl[7:`TSB_FLAG_LSB];

    // ------------------------------------------------------------
    // compare match, wrap and capture events
    // ------------------------------------------------------------
    assign match_a = COUNT_TICK && (free_counter == compare_a_value);
    assign match_b = COUNT_TICK && (free_counter == compare_b_value);
    assign wrap = COUNT_TICK && (free_counter == `TSB_COUNT_MAX);

    tsb_capture_sync u_capture_sync
    (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .pin(CAPTURE_PIN),
        .rise(cap_rise),
        .fall(cap_fall)
    );

    assign cap_edge = ctrl[`TSB_BIT_CAPTURE_EDGE_SEL] ? cap_rise : cap_fall;
    assign cap_hi_read = CPU_RD && (sel == TSB_SEL_CAP_HI);
    assign cap_fire = (cap_edge && !cap_hi_read) || cap_pending;

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            cap_pending <= 1'b0;
        else if (STANDBY)
            cap_pending <= 1'b0;
        else
            cap_pending <= cap_edge && cap_hi_read;
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    assign flag_set = {cap_fire, match_b, match_a, wrap};
    assign xfer_clr = {XFER_SERVE_CAPTURE, XFER_SERVE_MATCH_B,
        XFER_SERVE_MATCH_A, 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_flag
            // only a write of 0 after a read of 1 clears
            assign sw_clr[gi] = wr_ctrl && !CPU_WDATA[gi + `TSB_FLAG_LSB]
                && armed[gi];

            always_ff @(posedge SYS_CLK or negedge RST_B)
            begin
                if (!RST_B)
                    ctrl[gi + `TSB_FLAG_LSB] <= 1'b0;
                else if (STANDBY)
                    ctrl[gi + `TSB_FLAG_LSB] <= 1'b0;
                else if (flag_set[gi])
                    ctrl[gi + `TSB_FLAG_LSB] <= 1'b1;
                else if (sw_clr[gi] || xfer_clr[gi])
                    ctrl[gi + `TSB_FLAG_LSB] <= 1'b0;
            end

            always_ff @(posedge SYS_CLK or negedge RST_B)
            begin
                if (!RST_B)
                    armed[gi] <= 1'b0;
                else if (STANDBY || wr_ctrl)
                    armed[gi] <= 1'b0;
                else if (rd_ctrl && flags[gi])
                    armed[gi] <= 1'b1;
                else if (!flags[gi])
                    armed[gi] <= 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            ctrl[3:0] <= rst_ctrl[3:0];
        else if (STANDBY)
            ctrl[3:0] <= rst_ctrl[3:0];
        else if (wr_ctrl)
            ctrl[3:0] <= CPU_WDATA[3:0];
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            free_counter <= `TSB_RST_COUNT;
        else if (STANDBY)
            free_counter <= `TSB_RST_COUNT;
        else if (CPU_WR && sel == TSB_SEL_CNT_LO)
            free_counter <= {hold, CPU_WDATA};
        else if (match_a && ctrl[`TSB_BIT_CLEAR_ON_MATCH_A])
            free_counter <= `TSB_RST_COUNT;
        else if (COUNT_TICK)
            free_counter <= free_counter + 16'h0001;
    end

    // ------------------------------------------------------------
    // compare and capture registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            compare_a_value <= `TSB_RST_COMPARE;
            compare_b_value <= `TSB_RST_COMPARE;
        end
        else if (STANDBY)
        begin
            compare_a_value <= `TSB_RST_COMPARE;
            compare_b_value <= `TSB_RST_COMPARE;
        end
        else if (CPU_WR && sel == TSB_SEL_CMPA_LO)
            compare_a_value <= {hold, CPU_WDATA};
        else if (CPU_WR && sel == TSB_SEL_CMPB_LO)
            compare_b_value <= {hold, CPU_WDATA};
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            capture_value <= `TSB_RST_CAPTURE;
        else if (STANDBY)
            capture_value <= `TSB_RST_CAPTURE;
        else if (cap_fire)
            capture_value <= free_counter;
    end

    // ------------------------------------------------------------
    // shared holding latch
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            hold <= 8'h00;
        else if (STANDBY)
            hold <= 8'h00;
        else if (CPU_WR && (sel == TSB_SEL_CNT_HI || sel == TSB_SEL_CMPA_HI
            || sel == TSB_SEL_CMPB_HI))
            hold <= CPU_WDATA;
        else if (CPU_RD && sel == TSB_SEL_CNT_HI)
            hold <= free_counter[7:0];
        else if (cap_hi_read)
            hold <= capture_value[7:0];
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            CPU_RDATA <= 8'h00;
        else if (CPU_RD)
        begin
            case (sel)
                TSB_SEL_CTRL: CPU_RDATA <= ctrl;
                TSB_SEL_CNT_HI: CPU_RDATA <= free_counter[15:8];
                TSB_SEL_CNT_LO: CPU_RDATA <= hold;
                TSB_SEL_CMPA_HI: CPU_RDATA <= compare_a_value[15:8];
                TSB_SEL_CMPA_LO: CPU_RDATA <= compare_a_value[7:0];
                TSB_SEL_CMPB_HI: CPU_RDATA <= compare_b_value[15:8];
                TSB_SEL_CMPB_LO: CPU_RDATA <= compare_b_value[7:0];
                TSB_SEL_CAP_HI: CPU_RDATA <= capture_value[15:8];
                TSB_SEL_CAP_LO: CPU_RDATA <= hold;
                default: CPU_RDATA <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // compare pins
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            COMPARE_A_OUT_PIN <= 1'b0;
            COMPARE_B_OUT_PIN <= 1'b0;
        end
        else if (STANDBY)
        begin
            COMPARE_A_OUT_PIN <= 1'b0;
            COMPARE_B_OUT_PIN <= 1'b0;
        end
        else
        begin
            if (match_a && OUT_ENABLE_A)
                COMPARE_A_OUT_PIN <= ctrl[`TSB_BIT_MATCH_A_LEVEL];
            if (match_b && OUT_ENABLE_B)
                COMPARE_B_OUT_PIN <= ctrl[`TSB_BIT_MATCH_B_LEVEL];
        end
    end

    // ------------------------------------------------------------
    // interrupt lines
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            CAPTURE_IRQ <= 1'b0;
            MATCH_B_IRQ <= 1'b0;
            MATCH_A_IRQ <= 1'b0;
            WRAP_IRQ <= 1'b0;
        end
        else
        begin
            CAPTURE_IRQ <= flags[3] && IRQ_ENABLE[3];
            MATCH_B_IRQ <= flags[2] && IRQ_ENABLE[2];
            MATCH_A_IRQ <= flags[1] && IRQ_ENABLE[1];
            WRAP_IRQ <= flags[0] && IRQ_ENABLE[0];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_capture_sets;
        @(posedge SYS_CLK) disable iff (!RST_B)
        cap_fire && !STANDBY |=> flags[3] && capture_value == $past(free_counter);
    endproperty
    a_capture_sets: assert property (p_capture_sets)
        else $error("capture did not load value and flag");

    property p_write_one_ignored;
        @(posedge SYS_CLK) disable iff (!RST_B)
        !flags[2] && wr_ctrl && CPU_WDATA[6] && !match_b && !STANDBY |=> !flags[2];
    endproperty
    a_write_one_ignored: assert property (p_write_one_ignored)
        else $error("write of one set a flag");

    property p_clear_needs_read;
        @(posedge SYS_CLK) disable iff (!RST_B)
        flags[0] && !armed[0] && wr_ctrl && !STANDBY |=> flags[0];
    endproperty
    a_clear_needs_read: assert property (p_clear_needs_read)
        else $error("flag cleared without prior read");

    property p_read_then_clear;
        @(posedge SYS_CLK) disable iff (!RST_B)
        rd_ctrl && flags[0] && !STANDBY ##1 !wr_ctrl ##1 wr_ctrl && !CPU_WDATA[4] && !wrap
        |=> !flags[0];
    endproperty
    a_read_then_clear: assert property (p_read_then_clear)
        else $error("read then write zero did not clear");

    property p_xfer_clear;
        @(posedge SYS_CLK) disable iff (!RST_B)
        XFER_SERVE_CAPTURE && !cap_fire |=> !flags[3];
    endproperty
    a_xfer_clear: assert property (p_xfer_clear)
        else $error("service did not clear capture flag");

    property p_match_flags;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (match_a || match_b) && !STANDBY |=> (flags[1] || !$past(match_a))
        && (flags[2] || !$past(match_b));
    endproperty
    a_match_flags: assert property (p_match_flags)
        else $error("compare match flag not set");

    property p_wrap;
        @(posedge SYS_CLK) disable iff (!RST_B)
        COUNT_TICK && free_counter == `TSB_COUNT_MAX && !CPU_WR && !STANDBY
        |=> free_counter == `TSB_RST_COUNT && flags[0];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap did not set flag");

    property p_clear_on_match;
        @(posedge SYS_CLK) disable iff (!RST_B)
        match_a && ctrl[0] && !CPU_WR && !STANDBY |=> free_counter == 16'h0000;
    endproperty
    a_clear_on_match: assert property (p_clear_on_match)
        else $error("counter not cleared on match a");

    property p_word_write;
        @(posedge SYS_CLK) disable iff (!RST_B)
        CPU_WR && sel == TSB_SEL_CMPA_LO && !STANDBY
        |=> compare_a_value == {$past(hold), $past(CPU_WDATA)};
    endproperty
    a_word_write: assert property (p_word_write)
        else $error("lower write did not load full word");

    property p_cmp_direct_read;
        @(posedge SYS_CLK) disable iff (!RST_B)
        CPU_RD && sel == TSB_SEL_CMPB_LO |=> CPU_RDATA == $past(compare_b_value[7:0]);
    endproperty
    a_cmp_direct_read: assert property (p_cmp_direct_read)
        else $error("compare read went through latch");

    property p_capture_delay;
        @(posedge SYS_CLK) disable iff (!RST_B)
        cap_edge && cap_hi_read && !STANDBY |-> !cap_fire ##1 cap_fire;
    endproperty
    a_capture_delay: assert property (p_capture_delay)
        else $error("capture not delayed by one cycle");

    property p_standby_clear;
        @(posedge SYS_CLK) disable iff (!RST_B)
        STANDBY |=> ctrl == `TSB_RST_CTRL_STATUS || $past(flag_set) != 4'h0;
    endproperty
    a_standby_clear: assert property (p_standby_clear)
        else $error("standby did not clear status register");
endmodule

`default_nettype wire

// ===== verif/tsb_cpu_model.sv
// bus master model: cpu and transfer controller on the byte bus
// assumes strobes are taken at rising clk and driven at falling clk
`default_nettype none
module tsb_cpu_model
(
    // clock
    input wire logic clk,
    // byte bus
    output logic [3:0] addr,
    output logic rd,
    output logic wr,
    output tsb_pkg::tsb_byte_t wdata,
    input wire tsb_pkg::tsb_byte_t rdata,
    // service strobes: [0] capture [1] match a [2] match b
    output logic [2:0] serve
);
    timeunit 1ns;
    timeprecision 1ns;
    import tsb_pkg::*;
    // ------------------------------------------------------------
    // byte and word access
    // ------------------------------------------------------------
    initial
    begin
        addr = 4'h0;
        rd = 1'h0;
        wr = 1'h0;
        wdata = 8'h00;
        serve = 3'h0;
    end
    task automatic acc(input logic w, input logic [3:0] a, input tsb_byte_t d,
        output tsb_byte_t q);
        @(negedge clk);
        addr = a;
        rd = !w;
        wr = w;
        wdata = d;
        @(negedge clk);
        q = rdata;
        rd = 1'h0;
        wr = 1'h0;
        wdata = ~d;
    endtask
    // upper byte always first, for word writes and word reads alike
    task automatic put16(input logic [3:0] a, input tsb_word_t v);
        tsb_byte_t q;
        acc(1'h1, a, v[15:8], q);
        acc(1'h1, a + 4'h1, v[7:0], q);
    endtask
    task automatic get16(input logic [3:0] a, output tsb_word_t v);
        acc(1'h0, a, 8'h00, v[15:8]);
        acc(1'h0, a + 4'h1, 8'h00, v[7:0]);
    endtask
    task automatic pulse(input int i);
        @(negedge clk);
        serve[i] = 1'h1;
        @(negedge clk);
        serve[i] = 1'h0;
    endtask
endmodule
`default_nettype wire

// ===== verif/test_timer_status_byte_access.sv
// self-checking bench for the timer status block
// assumes tsb_regs.svh on the include path and tsb_cpu_model as bus master
`include "tsb_regs.svh"
`default_nettype none
module test_timer_status_byte_access;
    timeunit 1ns;
    timeprecision 1ns;
    import tsb_pkg::*;
    // ------------------------------------------------------------
    // signals, instances, tasks
    // ------------------------------------------------------------
    localparam logic [3:0] cs = `TSB_ADDR_CTRL_STATUS;
    localparam logic [3:0] cnt = `TSB_ADDR_COUNT_HI;
    localparam logic [3:0] ca = `TSB_ADDR_CMP_A_HI;
    localparam logic [3:0] cb = `TSB_ADDR_CMP_B_HI;
    localparam logic [3:0] cap = `TSB_ADDR_CAPT_HI;
    logic sys_clk = 1'h0, rst_b = 1'h0, standby = 1'h0, tick = 1'h0, cpin = 1'h1;
    logic out_a = 1'h0, out_b = 1'h0, rd, wr, pin_a, pin_b, irq_c, irq_a, irq_b, irq_w;
    logic [3:0] irq_en = 4'hF;
    logic [3:0] addr;
    logic [2:0] serve;
    tsb_byte_t wdata, rdata;
    int miscompares = 0;
    int num_checks = 0;
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    tsb_cpu_model tsb_cpu_model_inst (.clk(sys_clk), .addr(addr), .rd(rd), .wr(wr),
        .wdata(wdata), .rdata(rdata), .serve(serve));
    tsb_timer_status tsb_timer_status_inst (.SYS_CLK(sys_clk), .RST_B(rst_b),
        .STANDBY(standby), .CPU_ADDR(addr), .CPU_RD(rd), .CPU_WR(wr), .CPU_WDATA(wdata),
        .CPU_RDATA(rdata), .COUNT_TICK(tick), .CAPTURE_PIN(cpin), .IRQ_ENABLE(irq_en),
        .OUT_ENABLE_A(out_a), .OUT_ENABLE_B(out_b), .XFER_SERVE_CAPTURE(serve[0]),
        .XFER_SERVE_MATCH_A(serve[1]), .XFER_SERVE_MATCH_B(serve[2]),
        .COMPARE_A_OUT_PIN(pin_a), .COMPARE_B_OUT_PIN(pin_b), .CAPTURE_IRQ(irq_c),
        .MATCH_A_IRQ(irq_a), .MATCH_B_IRQ(irq_b), .WRAP_IRQ(irq_w));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd8(input logic [3:0] a, input tsb_byte_t exp);
        tsb_byte_t q;
        tsb_cpu_model_inst.acc(1'h0, a, 8'h00, q);
        check($sformatf("byte at %h", a), {8'h00, q}, {8'h00, exp});
    endtask
    task automatic wr8(input logic [3:0] a, input tsb_byte_t d);
        tsb_byte_t q;
        tsb_cpu_model_inst.acc(1'h1, a, d, q);
    endtask
    task automatic rd16(input logic [3:0] a, input tsb_word_t exp);
        tsb_word_t v;
        tsb_cpu_model_inst.get16(a, v);
        check($sformatf("word at %h", a), v, exp);
    endtask
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(negedge sys_clk);
            tick = 1'h1;
            @(negedge sys_clk);
            tick = 1'h0;
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        #50000;
        miscompares++;
        wrap_up;
    end
    initial
    begin
        repeat (8) @(negedge sys_clk);
        rst_b = 1'h1;
        rd8(cs, 8'h00);
        rd16(ca, 16'hFFFF);
        rd16(cap, 16'h0000);
        wr8(cs, 8'hFF);
        rd8(cs, 8'h0F);
        $display("test reset and access done");
        wr8(cs, 8'h05);
        tsb_cpu_model_inst.put16(ca, 16'h0010);
        wr8(cb, 8'h00);
        wr8(cnt + 4'h1, 8'h0E);
        rd16(cb, 16'hFFFF);
        rd16(cnt, 16'h000E);
        out_a = 1'h1;
        ticks(2);
        rd8(cs, 8'h05);
        ticks(1);
        wr8(cs, 8'h05);
        rd8(cs, 8'h25);
        check("pin a", pin_a, 16'h1);
        check("irq a", irq_a, 16'h1);
        rd16(cnt, 16'h0000);
        wr8(cs, 8'h05);
        rd8(cs, 8'h05);
        $display("test match a done");
        wr8(cs, 8'h08);
        out_b = 1'h1;
        tsb_cpu_model_inst.put16(cnt, 16'hFFFE);
        ticks(2);
        wr8(cs, 8'h08);
        rd8(cs, 8'h58);
        check("pin b", pin_b, 16'h1);
        check("irq wrap", irq_w, 16'h1);
        check("irq b", irq_b, 16'h1);
        irq_en = 4'hE;
        @(negedge sys_clk);
        check("irq wrap masked", irq_w, 16'h0);
        irq_en = 4'hF;
        tsb_cpu_model_inst.pulse(2);
        tsb_cpu_model_inst.pulse(1);
        rd8(cs, 8'h18);
        wr8(cs, 8'h08);
        rd8(cs, 8'h08);
        $display("test match b and wrap done");
        tsb_cpu_model_inst.put16(cnt, 16'h0100);
        cpin = 1'h0;
        repeat (6) @(negedge sys_clk);
        rd8(cs, 8'h88);
        rd16(cap, 16'h0100);
        wr8(cs, 8'h8A);
        tsb_cpu_model_inst.put16(cnt, 16'h0200);
        cpin = 1'h1;
        @(negedge sys_clk);
        rd16(cap, 16'h0100);
        rd16(cap, 16'h0200);
        check("irq capture", irq_c, 16'h1);
        tsb_cpu_model_inst.pulse(0);
        rd8(cs, 8'h0A);
        $display("test capture done");
        @(negedge sys_clk);
        standby = 1'h1;
        @(negedge sys_clk);
        standby = 1'h0;
        rd8(cs, 8'h00);
        rd16(ca, 16'hFFFF);
        $display("test standby done");
        wrap_up;
    end
endmodule
`default_nettype wire
